// file: core/eft_defines.svh
// Timing constants and timer width for the earth fault teleprotection block
`ifndef EFT_DEFINES_SVH
`define EFT_DEFINES_SVH
`define EFT_CLK_HZ          20000000
`define EFT_TICK_HZ         1000
`define EFT_TICK_DIV        (`EFT_CLK_HZ / `EFT_TICK_HZ)
`define EFT_SEC_DELAY_MS    20
`define EFT_HOLD_MS         100
`define EFT_FAIL_MS         10000
`define EFT_TIMER_W         16
`endif

// file: core/eft_pkg.sv
// Types shared by the earth fault teleprotection block
package eft_pkg;
  // Scheme selection
  typedef enum logic [1:0] {
    EFT_MODE_OFF     = 2'h0,
    EFT_MODE_UNBLOCK = 2'h1,
    EFT_MODE_BLOCK   = 2'h2
  } eft_mode_e;
  // Unblock logic states, one-hot
  typedef enum logic [3:0] {
    EFT_UB_QUIET   = 4'h1,
    EFT_UB_WAIT    = 4'h2,
    EFT_UB_RELEASE = 4'h4,
    EFT_UB_LOCKED  = 4'h8
  } eft_ub_state_e;
endpackage

// file: core/eft_unblock_chan.sv
// Unblock logic for one receive channel: release, security delay, hold and alarm
`include "eft_defines.svh"
module eft_unblock_chan
  import eft_pkg::*;
#(
  parameter int FAIL_MS = `EFT_FAIL_MS
) (
  // Clock, reset and millisecond tick
  input  wire logic ref_clk_in,
  input  wire logic reset_n_in,
  input  wire logic tick_in,
  // Synchronised carrier inputs
  input  wire logic unblock_tone_in,
  input  wire logic guard_tone_in,
  // Results
  output logic      release_out,
  output logic      alarm_out
);
  localparam logic [`EFT_TIMER_W-1:0] SEC_MS  = `EFT_TIMER_W'(`EFT_SEC_DELAY_MS);
  localparam logic [`EFT_TIMER_W-1:0] HOLD_MS = `EFT_TIMER_W'(`EFT_HOLD_MS);
  localparam logic [`EFT_TIMER_W-1:0] FAIL_T  = `EFT_TIMER_W'(FAIL_MS);

  eft_ub_state_e           state_q;   // Unblock state
  logic [`EFT_TIMER_W-1:0] tmr_q;     // Shared phase timer
  logic [`EFT_TIMER_W-1:0] fail_q;    // Silence timer for the alarm
  logic                    silent;    // Neither tone present
  logic                    rel_d;     // Next release value

  assign silent = !unblock_tone_in && !guard_tone_in;

  // Unblock state machine; timer restarts on every state change
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= EFT_UB_QUIET;
      tmr_q   <= '0;
    end else begin
      unique case (state_q)
        EFT_UB_QUIET: begin
          tmr_q <= '0;
          if (silent) state_q <= EFT_UB_WAIT;
        end
        EFT_UB_WAIT: begin
          if (!silent) begin
            state_q <= EFT_UB_QUIET;
            tmr_q   <= '0;
          end else if (tick_in && tmr_q == SEC_MS - 1'b1) begin
            state_q <= EFT_UB_RELEASE;
            tmr_q   <= '0;
          end else if (tick_in) begin
            tmr_q <= tmr_q + 1'b1;
          end
        end
        EFT_UB_RELEASE: begin
          // Release is withdrawn after the hold even if silence persists
          if (tick_in && tmr_q == HOLD_MS - 1'b1) begin
            state_q <= EFT_UB_LOCKED;
            tmr_q   <= '0;
          end else if (tick_in) begin
            tmr_q <= tmr_q + 1'b1;
          end
        end
        EFT_UB_LOCKED: begin
          // Dropout: a tone must stand for the full hold before quiet returns
          if (silent) begin
            tmr_q <= '0;
          end else if (tick_in && tmr_q == HOLD_MS - 1'b1) begin
            state_q <= EFT_UB_QUIET;
            tmr_q   <= '0;
          end else if (tick_in) begin
            tmr_q <= tmr_q + 1'b1;
          end
        end
      endcase
    end
  end

  // Release: direct path only when quiet, timed path in release phase
  always_comb begin
    rel_d = 1'b0;
    if (state_q == EFT_UB_QUIET) rel_d = unblock_tone_in && !guard_tone_in;
    if (state_q == EFT_UB_RELEASE) rel_d = 1'b1;
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) release_out <= 1'b0;
    else release_out <= rel_d;
  end

  // Link loss alarm after more than the fail time of silence
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fail_q    <= '0;
      alarm_out <= 1'b0;
    end else if (!silent) begin
      fail_q    <= '0;
      alarm_out <= 1'b0;
    end else if (tick_in) begin
      if (fail_q > FAIL_T) alarm_out <= 1'b1;
      else fail_q <= fail_q + 1'b1;
    end
  end
endmodule

// file: core/eft_trans_block.sv
// Transient blocking: wait-time qualify, then hold for the block time
`include "eft_defines.svh"
module eft_trans_block (
  // Clock, reset and millisecond tick
  input  wire logic                    ref_clk_in,
  input  wire logic                    reset_n_in,
  input  wire logic                    tick_in,
  // Settings in milliseconds
  input  wire logic [`EFT_TIMER_W-1:0] wait_ms_in,
  input  wire logic [`EFT_TIMER_W-1:0] hold_ms_in,
  // Criterion and qualifier window
  input  wire logic                    crit_in,
  input  wire logic                    arm_in,
  // Held output
  output logic                         hold_out
);
  logic [`EFT_TIMER_W-1:0] age_q;   // Time the arm window has been open
  logic [`EFT_TIMER_W-1:0] hold_q;  // Remaining hold time
  logic                    armed;   // Criterion seen within the wait time

  // arm_in high: age counts while window open; qualify when crit inside window
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) age_q <= '0;
    else if (!arm_in) age_q <= '0;
    else if (tick_in && age_q != {`EFT_TIMER_W{1'b1}}) age_q <= age_q + 1'b1;
  end

  assign armed = crit_in && arm_in && (age_q < wait_ms_in);

  // Hold: set while qualified, then runs out over the hold time after release
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hold_q   <= '0;
      hold_out <= 1'b0;
    end else if (armed || (hold_out && crit_in)) begin
      hold_q   <= hold_ms_in;
      hold_out <= 1'b1;
    end else if (hold_out && tick_in) begin
      if (hold_q == '0) hold_out <= 1'b0;
      else hold_q <= hold_q - 1'b1;
    end
  end
endmodule

// file: core/eft_teleprot.sv
// Earth fault teleprotection scheme logic for one line end
`include "eft_defines.svh"
module eft_teleprot
  import eft_pkg::*;
#(
  parameter int NPH      = 3,
  parameter int FAIL_MS  = `EFT_FAIL_MS,
  parameter int TICK_DIV = `EFT_TICK_DIV
) (
  // Clock and reset
  input  wire logic                    ref_clk_in,
  input  wire logic                    reset_n_in,
  // Configuration
  input  wire logic [1:0]              mode_in,
  input  wire logic                    three_term_in,
  input  wire logic [`EFT_TIMER_W-1:0] send_ext_ms_in,
  input  wire logic [`EFT_TIMER_W-1:0] trip_delay_ms_in,
  input  wire logic [`EFT_TIMER_W-1:0] transient_wait_time_in,
  input  wire logic [`EFT_TIMER_W-1:0] transient_hold_time_in,
  // Protection decisions, directional ones per phase, the rest shared (same clock)
  input  wire logic [NPH-1:0]          fwd_fault_in,
  input  wire logic [NPH-1:0]          rev_fault_in,
  input  wire logic                    nondir_fault_in,
  input  wire logic                    fault_pickup_in,
  input  wire logic                    trip_issued_in,
  input  wire logic                    jump_detect_in,
  // Carrier receive pins, per phase (asynchronous)
  input  wire logic [NPH-1:0]          unblock_tone_rx_ch1_in,
  input  wire logic [NPH-1:0]          guard_tone_rx_ch1_in,
  input  wire logic [NPH-1:0]          unblock_tone_rx_ch2_in,
  input  wire logic [NPH-1:0]          guard_tone_rx_ch2_in,
  input  wire logic [NPH-1:0]          block_rx_ch1_in,
  input  wire logic [NPH-1:0]          block_rx_ch2_in,
  // Transmit keying
  output logic [NPH-1:0]               unblock_tone_tx_out,
  output logic [NPH-1:0]               guard_tone_tx_out,
  output logic [NPH-1:0]               block_send_out,
  output logic [NPH-1:0]               block_stop_out,
  output logic                         jump_block_send_out,
  // Results
  output logic [NPH-1:0]               trip_release_out,
  output logic                         echo_request_out,
  output logic                         link_loss_alarm_ch1_out,
  output logic                         link_loss_alarm_ch2_out
);
  // Divider count is a parameter so a faster clock or a short test tick can set it
  localparam logic [15:0] TICK_LAST = 16'(TICK_DIV - 1);

  logic [15:0]          div_q;       // Millisecond divider
  logic                 tick;        // One-cycle millisecond enable
  logic [4*NPH-1:0]     ub_s1_q;     // Tone synchroniser stage 1
  logic [4*NPH-1:0]     ub_s2_q;     // Tone synchroniser stage 2
  logic [2*NPH-1:0]     bl_s1_q;     // Block synchroniser stage 1
  logic [2*NPH-1:0]     bl_s2_q;     // Block synchroniser stage 2
  logic [NPH-1:0]       rel1;        // Channel 1 unblock release
  logic [NPH-1:0]       rel2;        // Channel 2 unblock release
  logic [NPH-1:0]       al1;         // Channel 1 alarms per phase
  logic [NPH-1:0]       al2;         // Channel 2 alarms per phase
  logic                 is_ub;       // Unblock mode active
  logic                 is_bl;       // Blocking mode active
  logic                 tb_perm;     // Permissive transient inhibit
  logic [NPH-1:0]       blk_rx;      // Combined block receive
  logic [NPH-1:0]       blk_held;    // Block receive with transient hold
  logic                 any_fault;   // Local earth fault seen anywhere

  assign is_ub     = (mode_in == EFT_MODE_UNBLOCK);
  assign is_bl     = (mode_in == EFT_MODE_BLOCK);
  assign any_fault = fault_pickup_in || (|fwd_fault_in) || (|rev_fault_in);

  // Millisecond tick divider; all scheme timers run on this enable
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) div_q <= '0;
    else if (div_q == TICK_LAST) div_q <= '0;
    else div_q <= div_q + 1'b1;
  end
  assign tick = (div_q == TICK_LAST);

  // Two-stage synchronisers on the carrier pins; stage 1 feeds stage 2 only
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ub_s1_q <= '0;
      ub_s2_q <= '0;
      bl_s1_q <= '0;
      bl_s2_q <= '0;
    end else begin
      ub_s1_q <= {guard_tone_rx_ch2_in, unblock_tone_rx_ch2_in,
                  guard_tone_rx_ch1_in, unblock_tone_rx_ch1_in};
      ub_s2_q <= ub_s1_q;
      bl_s1_q <= {block_rx_ch2_in, block_rx_ch1_in};
      bl_s2_q <= bl_s1_q;
    end
  end

  // Permissive transient blocking: early reverse or undirected fault
  eft_trans_block u_tb_perm (
    .ref_clk_in (ref_clk_in),
    .reset_n_in (reset_n_in),
    .tick_in    (tick),
    .wait_ms_in (transient_wait_time_in),
    .hold_ms_in (transient_hold_time_in),
    .crit_in    ((|rev_fault_in) || nondir_fault_in),
    .arm_in     (fault_pickup_in),
    .hold_out   (tb_perm)
  );

  // One send/receive circuit per phase, each with two unblock channels
  for (genvar p = 0; p < NPH; p++) begin : g_ph
    logic                    send_q;     // Send request incl. extension
    logic [`EFT_TIMER_W-1:0] ext_q;      // Send extension countdown
    logic [`EFT_TIMER_W-1:0] tv_q;       // Blocking trip delay counter
    logic                    ub_rx;      // Combined unblock receive
    logic                    send_raw;   // Undelayed send condition

    eft_unblock_chan #(.FAIL_MS(FAIL_MS)) u_ch1 (
      .ref_clk_in      (ref_clk_in),
      .reset_n_in      (reset_n_in),
      .tick_in         (tick),
      .unblock_tone_in (ub_s2_q[p]),
      .guard_tone_in   (ub_s2_q[NPH+p]),
      .release_out     (rel1[p]),
      .alarm_out       (al1[p])
    );
    // Second channel runs independently for the far third terminal
    eft_unblock_chan #(.FAIL_MS(FAIL_MS)) u_ch2 (
      .ref_clk_in      (ref_clk_in),
      .reset_n_in      (reset_n_in),
      .tick_in         (tick),
      .unblock_tone_in (ub_s2_q[2*NPH+p]),
      .guard_tone_in   (ub_s2_q[3*NPH+p]),
      .release_out     (rel2[p]),
      .alarm_out       (al2[p])
    );

    // Three terminals need both ends to agree; two use channel 1
    assign ub_rx = three_term_in ? (rel1[p] && rel2[p]) : rel1[p];
    // Blocking receive: any far end blocks
    assign blk_rx[p] = three_term_in ? (bl_s2_q[p] || bl_s2_q[NPH+p])
                                     : bl_s2_q[p];

    // Raw send: forward in unblock mode, reverse without forward in blocking
    always_comb begin
      send_raw = 1'b0;
      if (is_ub) send_raw = fwd_fault_in[p] && !tb_perm;
      if (is_bl) send_raw = rev_fault_in[p] && !fwd_fault_in[p];
    end

    // Send extension: in blocking unless a forward fault cuts it, only after a trip in unblock mode
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        send_q <= 1'b0;
        ext_q  <= '0;
      end else if (send_raw) begin
        send_q <= 1'b1;
        ext_q  <= send_ext_ms_in;
      end else if (is_bl && fwd_fault_in[p]) begin
        send_q <= 1'b0;
        ext_q  <= '0;
      end else if (send_q && (is_bl || (is_ub && trip_issued_in)) && ext_q != '0) begin
        if (tick) ext_q <= ext_q - 1'b1;
      end else begin
        send_q <= 1'b0;
        ext_q  <= '0;
      end
    end

    // Blocking trip delay: forward fault with no block received
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) tv_q <= '0;
      else if (!(is_bl && fwd_fault_in[p] && !blk_held[p])) tv_q <= '0;
      else if (tick && tv_q != trip_delay_ms_in) tv_q <= tv_q + 1'b1;
    end

    // Registered keying and trip release outputs
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        unblock_tone_tx_out[p] <= 1'b0;
        guard_tone_tx_out[p]   <= 1'b0;
        block_send_out[p]      <= 1'b0;
        block_stop_out[p]      <= 1'b0;
        trip_release_out[p]    <= 1'b0;
      end else begin
        unblock_tone_tx_out[p] <= is_ub && send_q;
        guard_tone_tx_out[p]   <= is_ub && !send_q;
        block_send_out[p]      <= is_bl && send_q;
        block_stop_out[p]      <= is_bl && fwd_fault_in[p];
        if (is_ub)
          trip_release_out[p] <= ub_rx && fwd_fault_in[p] && !tb_perm;
        else if (is_bl)
          trip_release_out[p] <= fwd_fault_in[p] && !blk_held[p] &&
                                 tv_q == trip_delay_ms_in;
        else
          trip_release_out[p] <= 1'b0;
      end
    end
  end

  // Held block receive: only a receive that stood through the wait time is
  // prolonged, so a short blip does not hold off the trip
  for (genvar q = 0; q < NPH; q++) begin : g_hold
    logic [`EFT_TIMER_W-1:0] age_q;   // Time the block receive has stood
    logic [`EFT_TIMER_W-1:0] left_q;  // Remaining hold time
    logic                    h_q;     // Hold running
    logic                    qual;    // Receive stood for the wait time

    assign qual = blk_rx[q] && (age_q >= transient_wait_time_in);

    // Presence timer saturates, so a long block stays qualified
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) age_q <= '0;
      else if (!blk_rx[q]) age_q <= '0;
      else if (tick && age_q != {`EFT_TIMER_W{1'b1}}) age_q <= age_q + 1'b1;
    end

    // Hold reloads while qualified, then runs out over the hold time
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        left_q <= '0;
        h_q    <= 1'b0;
      end else if (qual) begin
        left_q <= transient_hold_time_in;
        h_q    <= 1'b1;
      end else if (h_q && tick) begin
        if (left_q == '0) h_q <= 1'b0;
        else left_q <= left_q - 1'b1;
      end
    end
    // Raw receive blocks at once; held copy covers only the transient tail
    assign blk_held[q] = blk_rx[q] || h_q;
  end

  // Echo request, jump keying and alarms
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      echo_request_out        <= 1'b0;
      jump_block_send_out     <= 1'b0;
      link_loss_alarm_ch1_out <= 1'b0;
      link_loss_alarm_ch2_out <= 1'b0;
    end else begin
      // Any one far end suffices on three-terminal lines; not in blocking
      echo_request_out <= is_ub && !any_fault &&
                          ((|rel1) || (three_term_in && (|rel2)));
      // Far side must respond promptly to the jump signal dropping
      jump_block_send_out     <= is_bl && jump_detect_in;
      link_loss_alarm_ch1_out <= is_ub && (|al1);
      link_loss_alarm_ch2_out <= is_ub && three_term_in && (|al2);
    end
  end
endmodule

// file: dv/eft_teleprot_checker.sv
// Port-level assertions for the earth fault teleprotection scheme block
module eft_teleprot_checker #(
  parameter int NPH = 3
) (
  // Clock, reset and protection decisions
  input wire logic           ref_clk_in,
  input wire logic           reset_n_in,
  input wire logic [1:0]     mode_in,
  input wire logic [NPH-1:0] fwd_fault_in,
  input wire logic [NPH-1:0] rev_fault_in,
  input wire logic           fault_pickup_in,
  input wire logic           trip_issued_in,
  input wire logic           jump_detect_in,
  // Keying and results
  input wire logic [NPH-1:0] unblock_tone_tx_out,
  input wire logic [NPH-1:0] guard_tone_tx_out,
  input wire logic [NPH-1:0] block_send_out,
  input wire logic [NPH-1:0] block_stop_out,
  input wire logic [NPH-1:0] trip_release_out,
  input wire logic           jump_block_send_out,
  input wire logic           echo_request_out
);
  default clocking @(posedge ref_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  // Steady conditions on phase 0; keying passes send and output registers, so three
  // cycles; the stop output has one register, so two
  sequence s_ub_fwd;
    mode_in == 2'h1 && fwd_fault_in[0] && !rev_fault_in[0];
  endsequence
  sequence s_ub_idle;
    mode_in == 2'h1 && !fwd_fault_in[0] && !trip_issued_in;
  endsequence
  sequence s_bl_rev;
    mode_in == 2'h2 && rev_fault_in[0] && !fwd_fault_in[0];
  endsequence
  sequence s_bl_fwd;
    mode_in == 2'h2 && fwd_fault_in[0];
  endsequence
  a_fwd_keys_unblock: assert property (
    s_ub_fwd [*3] |-> unblock_tone_tx_out[0] && !guard_tone_tx_out[0])
    else $error("unblock tone not keyed on forward fault");
  a_idle_keys_guard: assert property (
    s_ub_idle [*3] |-> guard_tone_tx_out[0] && !unblock_tone_tx_out[0])
    else $error("guard tone not keyed while quiet");
  a_rev_sends_block: assert property (
    s_bl_rev [*3] |-> block_send_out[0])
    else $error("block not sent on reverse fault");
  a_fwd_stops_block: assert property (
    s_bl_fwd [*2] |-> block_stop_out[0])
    else $error("block stop missing on forward fault");
  a_stop_only_fwd: assert property (
    block_stop_out[0] |-> $past(fwd_fault_in[0]) && $past(mode_in) == 2'h2)
    else $error("block stop without forward fault");
  a_trip_needs_fwd: assert property (
    trip_release_out[0] |-> $past(fwd_fault_in[0]))
    else $error("trip release without forward fault");
  a_jump_in_block: assert property (
    $rose(jump_block_send_out) |-> $past(jump_detect_in) && $past(mode_in) == 2'h2)
    else $error("jump send outside blocking scheme");
  a_echo_no_fault: assert property (
    echo_request_out |-> $past(mode_in) == 2'h1 && !$past(fault_pickup_in))
    else $error("echo despite local fault or wrong scheme");
endmodule

bind eft_teleprot eft_teleprot_checker #(.NPH(NPH)) eft_teleprot_checker_inst (.*);

// file: dv/eft_carrier_model.sv
// Carrier channel model: far-end relays keying tones and block signals
module eft_carrier_model (
  // Clock and far-end commands
  input  wire logic       ref_clk_in,
  input  wire logic [2:0] far_fwd_ch1_in,
  input  wire logic [2:0] far_fwd_ch2_in,
  input  wire logic [2:0] far_block_ch1_in,
  input  wire logic [2:0] far_block_ch2_in,
  input  wire logic       far_dead_ch1_in,
  input  wire logic       far_dead_ch2_in,
  // Receive pins toward the block
  output logic [2:0]      unblock_ch1_out,
  output logic [2:0]      guard_ch1_out,
  output logic [2:0]      unblock_ch2_out,
  output logic [2:0]      guard_ch2_out,
  output logic [2:0]      block_ch1_out,
  output logic [2:0]      block_ch2_out
);
  // Far end keys unblock on its forward fault, guard otherwise; a dead link loses both
  always_ff @(posedge ref_clk_in) begin
    unblock_ch1_out <= far_dead_ch1_in ? 3'h0 : far_fwd_ch1_in;
    guard_ch1_out   <= far_dead_ch1_in ? 3'h0 : ~far_fwd_ch1_in;
    unblock_ch2_out <= far_dead_ch2_in ? 3'h0 : far_fwd_ch2_in;
    guard_ch2_out   <= far_dead_ch2_in ? 3'h0 : ~far_fwd_ch2_in;
  end
  // Block keying passes as commanded; the channel answers promptly when it drops
  always_ff @(posedge ref_clk_in) begin
    block_ch1_out <= far_block_ch1_in;
    block_ch2_out <= far_block_ch2_in;
  end
endmodule

// file: dv/testbench.sv
// Self-checking bench for the earth fault teleprotection scheme block
`include "eft_defines.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import eft_pkg::*;
  localparam int MS      = 20;            // Short tick: cycles per millisecond
  localparam int FAIL_MS = 2;             // Short alarm time keeps the run brief
  localparam int LIMIT   = 20000;         // Run needs about 5500 cycles
  // Settings and decisions
  logic                    ref_clk_in, reset_n_in, three_term_in;
  logic                    nondir_fault_in, fault_pickup_in, trip_issued_in, jump_detect_in;
  logic [1:0]              mode_in;
  logic [`EFT_TIMER_W-1:0] send_ext_ms_in, trip_delay_ms_in;
  logic [`EFT_TIMER_W-1:0] transient_wait_time_in, transient_hold_time_in;
  logic [2:0]              fwd_fault_in, rev_fault_in;
  // Carrier pins, one bit a phase
  logic [2:0]              unblock_tone_rx_ch1_in, guard_tone_rx_ch1_in, block_rx_ch1_in;
  logic [2:0]              unblock_tone_rx_ch2_in, guard_tone_rx_ch2_in, block_rx_ch2_in;
  // Design outputs
  logic [2:0]              unblock_tone_tx_out, guard_tone_tx_out, block_send_out;
  logic [2:0]              block_stop_out, trip_release_out;
  logic                    jump_block_send_out, echo_request_out;
  logic                    link_loss_alarm_ch1_out, link_loss_alarm_ch2_out;
  // Far-end commands
  logic [2:0]              far_fwd_ch1, far_fwd_ch2, far_block_ch1, far_block_ch2;
  logic                    far_dead_ch1, far_dead_ch2;
  int                      errors = 0;
  int                      checks = 0;
  int                      cycles = 0;

  eft_teleprot #(.NPH(3), .FAIL_MS(FAIL_MS), .TICK_DIV(MS)) eft_teleprot_inst (.*);
  eft_carrier_model eft_carrier_model_inst (
    .ref_clk_in(ref_clk_in), .far_fwd_ch1_in(far_fwd_ch1), .far_fwd_ch2_in(far_fwd_ch2),
    .far_block_ch1_in(far_block_ch1), .far_block_ch2_in(far_block_ch2),
    .far_dead_ch1_in(far_dead_ch1), .far_dead_ch2_in(far_dead_ch2),
    .unblock_ch1_out(unblock_tone_rx_ch1_in), .guard_ch1_out(guard_tone_rx_ch1_in),
    .unblock_ch2_out(unblock_tone_rx_ch2_in), .guard_ch2_out(guard_tone_rx_ch2_in),
    .block_ch1_out(block_rx_ch1_in), .block_ch2_out(block_rx_ch2_in));

  // Compare a seen value with the expected one
  task automatic chk(input logic [2:0] seen, input logic [2:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Inputs only move at falling edges
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask
  // Counts, verdict and end of run
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end
  // Cut a hang short
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == LIMIT) begin
      errors++;
      give_verdict();
    end
  end

  initial begin
    reset_n_in = 1'b0;
    mode_in = EFT_MODE_OFF;
    three_term_in = 1'b0;
    nondir_fault_in = 1'b0;
    fault_pickup_in = 1'b0;
    trip_issued_in = 1'b0;
    jump_detect_in = 1'b0;
    send_ext_ms_in = 16'h0004;
    trip_delay_ms_in = 16'h0002;
    transient_wait_time_in = 16'h0001;
    transient_hold_time_in = 16'h0002;
    fwd_fault_in = 3'h0;
    rev_fault_in = 3'h0;
    far_fwd_ch1 = 3'h0;
    far_fwd_ch2 = 3'h0;
    far_block_ch1 = 3'h0;
    far_block_ch2 = 3'h0;
    far_dead_ch1 = 1'b0;
    far_dead_ch2 = 1'b0;
    cyc(3);
    reset_n_in = 1'b1;
    // Unblock scheme, forward fault on phase 1 only
    mode_in = EFT_MODE_UNBLOCK;
    fwd_fault_in = 3'h2;
    far_fwd_ch1 = 3'h3;
    cyc(10);
    chk(unblock_tone_tx_out, 3'h2);
    chk(guard_tone_tx_out, 3'h5);
    chk(trip_release_out, 3'h2);
    // Three ends: second channel still on guard tone, so no release yet
    three_term_in = 1'b1;
    cyc(10);
    chk(trip_release_out, 3'h0);
    far_fwd_ch2 = 3'h2;
    cyc(10);
    chk(trip_release_out, 3'h2);
    // Tone received with no local fault asks for an echo
    fwd_fault_in = 3'h0;
    cyc(10);
    chk(unblock_tone_tx_out, 3'h0);
    chk({2'h0, echo_request_out}, 3'h1);
    far_fwd_ch2 = 3'h0;
    cyc(10);
    chk({2'h0, echo_request_out}, 3'h1);
    fault_pickup_in = 1'b1;
    fwd_fault_in = 3'h7;
    cyc(10);
    chk({2'h0, echo_request_out}, 3'h0);
    // Send extension only once a trip has been issued
    fault_pickup_in = 1'b0;
    fwd_fault_in = 3'h1;
    cyc(10);
    trip_issued_in = 1'b1;
    cyc(10);
    fwd_fault_in = 3'h0;
    cyc(10);
    chk(unblock_tone_tx_out, 3'h1);
    cyc(2 * MS + 100);
    chk(unblock_tone_tx_out, 3'h0);
    trip_issued_in = 1'b0;
    // Blocking scheme: reverse fault sends block, extended after it goes
    mode_in = EFT_MODE_BLOCK;
    three_term_in = 1'b0;
    far_fwd_ch1 = 3'h0;
    rev_fault_in = 3'h4;
    cyc(10);
    chk(block_send_out, 3'h4);
    rev_fault_in = 3'h0;
    cyc(10);
    chk(block_send_out, 3'h4);
    cyc(2 * MS + 100);
    chk(block_send_out, 3'h0);
    send_ext_ms_in = 16'h0000;
    rev_fault_in = 3'h4;
    cyc(10);
    fwd_fault_in = 3'h4;
    cyc(10);
    chk(block_send_out, 3'h0);
    chk(block_stop_out, 3'h4);
    // Trip only after the delay with no block received
    rev_fault_in = 3'h0;
    cyc(MS / 2);
    chk(trip_release_out, 3'h0);
    cyc(3 * MS);
    chk(trip_release_out, 3'h4);
    fwd_fault_in = 3'h0;
    trip_delay_ms_in = 16'h0000;
    far_block_ch1 = 3'h4;
    cyc(10);
    fwd_fault_in = 3'h4;
    cyc(2 * MS + 100);
    chk(trip_release_out, 3'h0);
    // A long block stays held for the hold time after it drops
    far_block_ch1 = 3'h0;
    cyc(MS / 2);
    chk(trip_release_out, 3'h0);
    cyc(4 * MS);
    chk(trip_release_out, 3'h4);
    // A block shorter than the wait time is not prolonged
    transient_wait_time_in = 16'h0003;
    far_block_ch1 = 3'h4;
    cyc(10);
    chk(trip_release_out, 3'h0);
    far_block_ch1 = 3'h0;
    cyc(10);
    chk(trip_release_out, 3'h4);
    // Three ends: a block from the second end alone prevents the trip
    fwd_fault_in = 3'h0;
    three_term_in = 1'b1;
    far_block_ch2 = 3'h4;
    cyc(10);
    fwd_fault_in = 3'h4;
    cyc(10);
    chk(trip_release_out, 3'h0);
    far_block_ch2 = 3'h0;
    fwd_fault_in = 3'h0;
    three_term_in = 1'b0;
    // Jump detector keys the transmitter in blocking only
    jump_detect_in = 1'b1;
    cyc(5);
    chk({2'h0, jump_block_send_out}, 3'h1);
    mode_in = EFT_MODE_UNBLOCK;
    cyc(5);
    chk({2'h0, jump_block_send_out}, 3'h0);
    jump_detect_in = 1'b0;
    // Channel 1 goes silent: no quick release, alarm after the fail time
    fwd_fault_in = 3'h1;
    far_fwd_ch1 = 3'h1;
    cyc(10);
    chk(trip_release_out, 3'h1);
    far_dead_ch1 = 1'b1;
    cyc(MS);
    chk(trip_release_out, 3'h0);
    chk({1'b0, link_loss_alarm_ch2_out, link_loss_alarm_ch1_out}, 3'h0);
    cyc(5 * MS);
    chk({1'b0, link_loss_alarm_ch2_out, link_loss_alarm_ch1_out}, 3'h1);
    // Timed release after the security delay, withdrawn after the hold
    cyc(20 * MS);
    chk(trip_release_out, 3'h1);
    cyc(100 * MS);
    chk(trip_release_out, 3'h0);
    // Tone back: direct path returns only after the dropout delay
    far_dead_ch1 = 1'b0;
    cyc(50 * MS);
    chk(trip_release_out, 3'h0);
    chk({2'h0, link_loss_alarm_ch1_out}, 3'h0);
    cyc(60 * MS);
    chk(trip_release_out, 3'h1);
    give_verdict();
  end
endmodule
